// ---- bench/tppc_checker.sv ----
// port assertions for the two-phase pulse counter
`timescale 1ns/1ps
module tppc_checker (
    // clock and bus
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // interrupt
    input wire logic irq
);
    logic [1:0] mask_seen;
    default clocking @(posedge sys_clk);
    endclocking
    default disable iff (reset);
    // taken at ack, one edge late, as irq lags the mask
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mask_seen <= 2'h0;
        end else if (wb_ack_o && wb_we_i && wb_adr_i == tppc_pkg::OFF_MASK && wb_sel_i[0]) begin
            mask_seen <= wb_dat_i[1:0];
        end
    end
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack");
    a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("stray ack");
    a_upper_zero: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:16] == 16'h0000)
        else $error("upper bits set");
    a_unmapped_zero: assert property (wb_ack_o && !wb_we_i && wb_adr_i[1:0] != 2'h0
        |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read");
    a_reset_quiet: assert property ($fell(reset) |-> !wb_ack_o && !irq)
        else $error("busy after reset");
    a_masked_quiet: assert property (mask_seen == 2'h0 |-> !irq)
        else $error("masked irq");
    a_irq_sticky: assert property (irq && !(wb_cyc_i && wb_we_i && wb_adr_i[3]) |=> irq)
        else $error("irq dropped");
endmodule

bind tppc_counter tppc_checker i_tppc_checker (.sys_clk(sys_clk), .reset(reset),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq(irq));

// ---- bench/tppc_counter_tb.sv ----
// self-checking bench for the two-phase pulse counter
`timescale 1ns/1ps
module tppc_counter_tb;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] rdat, q;
    logic ack, irq;
    logic [2:0] pins;
    int fail_count = 0;
    int tests_run = 0;
    // ctrl, start pins, four steps, expected count
    logic [29:0] rows [5] = '{{4'h1, 2'h1, 8'hDF, 16'h0101}, {4'h1, 2'h0, 8'h88, 16'h0100},
        {4'h5, 2'h0, 8'h78, 16'h0104}, {4'h5, 2'h0, 8'hB4, 16'h00FC},
        {4'h4, 2'h0, 8'h78, 16'h0100}};
    always #25 sys_clk = ~sys_clk;
    tppc_counter i_tppc_counter (.sys_clk(sys_clk), .reset(reset), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .phase_a_input(pins[2]), .phase_b_input(pins[1]),
        .z_phase_input(pins[0]), .irq(irq));
    tppc_encoder i_tppc_encoder (.sys_clk(sys_clk), .pins(pins));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d = 32'h0000_0000);
        int n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (ack !== 1'b1 && n < 16);
        if (ack !== 1'b1) fail_count++;
        q = rdat;
        cyc <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        #100_000;
        fail_count++;
        print_verdict();
    end
    initial begin
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        bus(1'b0, 4'h2);
        check(q, 32'h0000_0000);
        foreach (rows[i]) begin
            bus(1'b1, tppc_pkg::OFF_CTRL);
            i_tppc_encoder.move({rows[i][25:24], 1'b0}, 1);
            bus(1'b1, tppc_pkg::OFF_VALUE, 32'h0000_0100);
            bus(1'b1, tppc_pkg::OFF_CTRL, {28'h000_0000, rows[i][29:26]});
            for (int k = 3; k >= 0; k--) i_tppc_encoder.move({rows[i][16+2*k+:2], 1'b0}, i % 2 + 1);
            bus(1'b0, tppc_pkg::OFF_VALUE);
            check(q, {16'h0000, rows[i][15:0]});
        end
        // running write must wait for the wrap to reach the counter
        bus(1'b1, tppc_pkg::OFF_CTRL);
        i_tppc_encoder.move(3'h0, 1);
        bus(1'b1, tppc_pkg::OFF_VALUE, 32'h0000_FFFF);
        bus(1'b1, tppc_pkg::OFF_MASK, 32'h0000_0001);
        bus(1'b1, tppc_pkg::OFF_CTRL, 32'h0000_0007);
        // the idle cycle between the two writes is the wait after start
        bus(1'b1, tppc_pkg::OFF_VALUE, 32'h0000_0010);
        bus(1'b0, tppc_pkg::OFF_VALUE);
        check(q, 32'h0000_FFFF);
        i_tppc_encoder.move(3'h2, 1);
        bus(1'b0, tppc_pkg::OFF_VALUE);
        check(q, 32'h0000_0010);
        check({31'h0000_0000, irq}, 32'h0000_0001);
        bus(1'b1, tppc_pkg::OFF_STATUS, 32'h0000_0001);
        check({31'h0000_0000, irq}, 32'h0000_0000);
        bus(1'b1, tppc_pkg::OFF_CTRL);
        bus(1'b1, tppc_pkg::OFF_VALUE);
        bus(1'b1, tppc_pkg::OFF_CTRL, 32'h0000_0005);
        i_tppc_encoder.move(3'h0, 1);
        bus(1'b0, tppc_pkg::OFF_VALUE);
        check(q, 32'h0000_FFFF);
        bus(1'b0, tppc_pkg::OFF_STATUS);
        check(q, 32'h0000_0002);
        check({31'h0000_0000, irq}, 32'h0000_0000);
        bus(1'b1, tppc_pkg::OFF_CTRL, 32'h0000_000D);
        bus(1'b0, tppc_pkg::OFF_CTRL);
        check(q, 32'h0000_000D);
        i_tppc_encoder.move(3'h1, 1);
        i_tppc_encoder.move(3'h0, 1);
        bus(1'b0, tppc_pkg::OFF_VALUE);
        check(q, 32'h0000_0000);
        reset <= 1'b1;
        repeat (2) @(posedge sys_clk);
        reset <= 1'b0;
        @(posedge sys_clk);
        bus(1'b0, tppc_pkg::OFF_CTRL);
        check(q, 32'h0000_0000);
        print_verdict();
    end
endmodule

// ---- bench/tppc_encoder.sv ----
// encoder model driving the phase and index pins
`timescale 1ns/1ps
module tppc_encoder (
    // clock
    input wire logic sys_clk,
    // pins
    output logic [2:0] pins
);
    initial pins = 3'h0;
    // a, b, z levels; gap above one makes a slow encoder
    task automatic move(input logic [2:0] abz, input int gap);
        pins <= abz;
        repeat (gap) @(posedge sys_clk);
    endtask
endmodule

// ---- logic/tppc_counter.sv ----
// two-phase pulse counter with wishbone registers and interrupt
//
// Design decisions made here: the address map and the Wishbone register port.
`timescale 1ns/1ps
module tppc_counter (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // encoder pins
    input wire logic phase_a_input,
    input wire logic phase_b_input,
    input wire logic z_phase_input,
    // interrupt
    output logic irq
);
    tppc_pkg::tppc_ctrl_t ctrl;
    tppc_pkg::tppc_pins_t pins;
    tppc_pkg::tppc_step_t step;
    logic z_pulse;
    logic [15:0] count;
    logic [15:0] reload_value;
    logic [1:0] status;
    logic [1:0] mask;
    logic wr_strobe;
    logic rd_strobe;
    logic wr_ctrl;
    logic wr_value;
    logic wr_status;
    logic wr_mask;
    logic lo_lanes;
    logic counting;
    logic ovf;
    logic unf;
    logic [31:0] next_rdata;

    assign pins = '{a: phase_a_input, b: phase_b_input, z: z_phase_input};

    tppc_decoder u_decoder (
        .sys_clk(sys_clk),
        .reset(reset),
        .pins(pins),
        .quad(ctrl.quad),
        .step(step),
        .z_pulse(z_pulse)
    );

    // one wait state: ack one edge after the request, then dropped
    assign wr_strobe = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
    assign rd_strobe = wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o;
    assign lo_lanes = wb_sel_i[0];
    assign wr_ctrl = wr_strobe && wb_adr_i == tppc_pkg::OFF_CTRL && lo_lanes;
    assign wr_value = wr_strobe && wb_adr_i == tppc_pkg::OFF_VALUE;
    assign wr_status = wr_strobe && wb_adr_i == tppc_pkg::OFF_STATUS && lo_lanes;
    assign wr_mask = wr_strobe && wb_adr_i == tppc_pkg::OFF_MASK && lo_lanes;

    assign counting = ctrl.run;
    assign ovf = counting && step == tppc_pkg::TPPC_UP && count == tppc_pkg::VALUE_MAX;
    assign unf = counting && step == tppc_pkg::TPPC_DOWN && count == tppc_pkg::VALUE_RESET;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl <= tppc_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl.run <= wb_dat_i[tppc_pkg::CTRL_RUN_BIT];
            ctrl.reload <= wb_dat_i[tppc_pkg::CTRL_RELOAD_BIT];
            ctrl.quad <= wb_dat_i[tppc_pkg::CTRL_QUAD_BIT];
            ctrl.zrst <= wb_dat_i[tppc_pkg::CTRL_ZRST_BIT];
        end
    end

    // reload register: byte lanes 0 and 1 hold the 16-bit value
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            reload_value <= tppc_pkg::VALUE_RESET;
        end else if (wr_value) begin
            if (wb_sel_i[0]) reload_value[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) reload_value[15:8] <= wb_dat_i[15:8];
        end
    end

    // software load only while halted; running writes reach the count at a wrap, and only while reload is set
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            count <= tppc_pkg::VALUE_RESET;
        end else if (wr_value && !counting) begin
            if (wb_sel_i[0]) count[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1]) count[15:8] <= wb_dat_i[15:8];
        end else if (counting && ctrl.zrst && z_pulse) begin
            count <= tppc_pkg::VALUE_RESET;
        end else if ((ovf || unf) && ctrl.reload) begin
            count <= reload_value;
        end else if (counting && step == tppc_pkg::TPPC_UP) begin
            count <= count + 16'h0001;
        end else if (counting && step == tppc_pkg::TPPC_DOWN) begin
            count <= count - 16'h0001;
        end
    end

    // sticky events: a new event wins over a same-cycle clear
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            status <= tppc_pkg::IRQ_RESET;
        end else begin
            status[tppc_pkg::STAT_OVF_BIT] <= ovf | (status[tppc_pkg::STAT_OVF_BIT]
                & ~(wr_status & wb_dat_i[tppc_pkg::STAT_OVF_BIT]));
            status[tppc_pkg::STAT_UNF_BIT] <= unf | (status[tppc_pkg::STAT_UNF_BIT]
                & ~(wr_status & wb_dat_i[tppc_pkg::STAT_UNF_BIT]));
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            mask <= tppc_pkg::IRQ_RESET;
        end else if (wr_mask) begin
            mask <= wb_dat_i[1:0];
        end
    end

    // irq from a flop, so it follows status by one cycle
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status & mask);
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        unique case (wb_adr_i)
            // struct packs run at its top bit, so place each field by name
            tppc_pkg::OFF_CTRL: begin
                next_rdata[tppc_pkg::CTRL_RUN_BIT] = ctrl.run;
                next_rdata[tppc_pkg::CTRL_RELOAD_BIT] = ctrl.reload;
                next_rdata[tppc_pkg::CTRL_QUAD_BIT] = ctrl.quad;
                next_rdata[tppc_pkg::CTRL_ZRST_BIT] = ctrl.zrst;
            end
            tppc_pkg::OFF_VALUE: next_rdata[15:0] = count;
            tppc_pkg::OFF_STATUS: next_rdata[1:0] = status;
            tppc_pkg::OFF_MASK: next_rdata[1:0] = mask;
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rd_strobe) begin
            wb_dat_o <= next_rdata;
        end
    end
endmodule

// ---- logic/tppc_decoder.sv ----
// phase edge decoder: turns sampled A/B levels into count steps
`timescale 1ns/1ps
module tppc_decoder (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // pins and mode
    input wire tppc_pkg::tppc_pins_t pins,
    input wire logic quad,
    // decoded
    output tppc_pkg::tppc_step_t step,
    output logic z_pulse
);
    logic prev_a;
    logic prev_b;
    logic prev_z;
    logic rise_a;
    logic fall_a;
    logic rise_b;
    logic fall_b;

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            prev_a <= 1'b0;
            prev_b <= 1'b0;
            prev_z <= 1'b0;
        end else begin
            prev_a <= pins.a;
            prev_b <= pins.b;
            prev_z <= pins.z;
        end
    end

    assign rise_a = pins.a & ~prev_a;
    assign fall_a = ~pins.a & prev_a;
    assign rise_b = pins.b & ~prev_b;
    assign fall_b = ~pins.b & prev_b;
    assign z_pulse = pins.z & ~prev_z;

    always_comb begin
        step = tppc_pkg::TPPC_HOLD;
        if (!quad) begin
            // only A edges count, and only while B is high
            if (prev_b && pins.b && rise_a) step = tppc_pkg::TPPC_UP;
            else if (prev_b && pins.b && fall_a) step = tppc_pkg::TPPC_DOWN;
        end else if (rise_a ^ fall_a ^ rise_b ^ fall_b) begin
            // both phases moving in one sample is a glitch, so it is ignored
            if ((rise_a && pins.b) || (fall_a && !pins.b) || (rise_b && !pins.a)
                    || (fall_b && pins.a)) begin
                step = tppc_pkg::TPPC_UP;
            end else begin
                step = tppc_pkg::TPPC_DOWN;
            end
        end
    end
endmodule

// ---- shared/tppc_pkg.sv ----
// package for the two-phase pulse counter: register map, fields, resets
package tppc_pkg;
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_VALUE = 4'h4;
    localparam logic [3:0] OFF_STATUS = 4'h8;
    localparam logic [3:0] OFF_MASK = 4'hC;
    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_RELOAD_BIT = 1;
    localparam int CTRL_QUAD_BIT = 2;
    localparam int CTRL_ZRST_BIT = 3;
    localparam int STAT_OVF_BIT = 0;
    localparam int STAT_UNF_BIT = 1;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [15:0] VALUE_RESET = 16'h0000;
    localparam logic [15:0] VALUE_MAX = 16'hFFFF;
    localparam logic [1:0] IRQ_RESET = 2'h0;
    typedef struct packed {
        logic run;
        logic reload;
        logic quad;
        logic zrst;
    } tppc_ctrl_t;
    typedef struct packed {
        logic a;
        logic b;
        logic z;
    } tppc_pins_t;
    typedef enum logic [1:0] {
        TPPC_HOLD,
        TPPC_UP,
        TPPC_DOWN
    } tppc_step_t;
endpackage
